// ===== design/rcf_host.sv
// Host-side framer: sends binary frames with a trailing check and collects replies.
// Assumes a byte transceiver on mclk with valid/ready out and a valid strobe in.
`timescale 1ns/10ps
module rcf_host
  import rcf_pkg::*;
#(
  parameter int GAP_CYCLES = RCF_QUIET_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire rcf_req_type req,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  dat_byte,
  input  wire logic        dat_valid,
  output logic             dat_ready,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic [7:0]       rx_out_byte,
  output logic [7:0]       rx_out_pos,
  output logic             rx_out_stb,
  output logic             rx_done,
  output rcf_rx_type       rx_stat
);
  localparam int IW = $clog2(GAP_CYCLES + 2);
  localparam logic [IW-1:0] GAP_N  = IW'(GAP_CYCLES);
  localparam logic [IW-1:0] GAP_N1 = IW'(GAP_CYCLES + 1);

  if (GAP_CYCLES < 2) begin : g_gap_check
    $error("rcf_host: GAP_CYCLES must be at least 2");
  end

  typedef struct packed {
    rcf_tx_type  tx;
    rcf_req_type rq;
    logic [7:0]  cnt;
    logic [7:0]  txb;
    logic [15:0] crc_tx;
    logic [15:0] crc_rx;
    logic [IW-1:0] idle;
    logic [7:0]  rx_pos;
    logic [7:0]  rx_ob;
    logic [7:0]  rx_op;
    logic        rx_stb;
    logic        rx_done;
    rcf_rx_type  stat;
  } rcf_state_type;

  rcf_state_type st_r;
  rcf_state_type st_nxt;
  logic          tx_fire;

  assign tx_valid  = (st_r.tx inside {RCF_TX_ADDR, RCF_TX_OPERATION_CODE_FIELD, RCF_TX_LEN, RCF_TX_DATA,
                                      RCF_TX_CRCL, RCF_TX_CRCH});
  assign tx_fire   = tx_valid && tx_ready;
  assign req_ready = (st_r.tx == RCF_TX_IDLE);
  assign dat_ready = (st_r.tx == RCF_TX_FETCH);
  assign tx_byte   = st_r.txb;
  assign rx_out_byte = st_r.rx_ob;
  assign rx_out_pos  = st_r.rx_op;
  assign rx_out_stb  = st_r.rx_stb;
  assign rx_done     = st_r.rx_done;
  assign rx_stat     = st_r.stat;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_stb  = 1'b0;
    st_nxt.rx_done = 1'b0;

    // Any byte on the shared line, either way, restarts the quiet timer.
    if (tx_fire || rx_valid) begin
      st_nxt.idle = '0;
    end else if (st_r.idle != GAP_N1) begin
      st_nxt.idle = st_r.idle + IW'(1);
    end

    case (st_r.tx)
      RCF_TX_IDLE: begin
        if (req_valid) begin
          st_nxt.rq     = req;
          st_nxt.cnt    = req.count;
          st_nxt.crc_tx = RCF_CRC_INIT;
          st_nxt.tx     = RCF_TX_GAP;
        end
      end
      RCF_TX_GAP: begin
        if (st_r.idle == GAP_N1) begin
          st_nxt.txb    = st_r.rq.addr;
          st_nxt.crc_tx = rcf_crc_byte(st_r.crc_tx, st_r.rq.addr);
          st_nxt.tx     = RCF_TX_ADDR;
        end
      end
      RCF_TX_ADDR: begin
        if (tx_ready) begin
          st_nxt.txb    = st_r.rq.operation_code_field;
          st_nxt.crc_tx = rcf_crc_byte(st_r.crc_tx, st_r.rq.operation_code_field);
          st_nxt.tx     = RCF_TX_OPERATION_CODE_FIELD;
        end
      end
      RCF_TX_OPERATION_CODE_FIELD: begin
        if (tx_ready) begin
          st_nxt.txb    = st_r.rq.payload_length_field;
          st_nxt.crc_tx = rcf_crc_byte(st_r.crc_tx, st_r.rq.payload_length_field);
          st_nxt.tx     = RCF_TX_LEN;
        end
      end
      RCF_TX_LEN, RCF_TX_DATA: begin
        if (tx_ready) begin
          if (st_r.cnt == 8'h00) begin
            st_nxt.txb = st_r.crc_tx[7:0];
            st_nxt.tx  = RCF_TX_CRCL;
          end else begin
            st_nxt.tx  = RCF_TX_FETCH;
          end
        end
      end
      RCF_TX_FETCH: begin
        // The user supplies data in wire order, most significant byte first.
        if (dat_valid) begin
          st_nxt.txb    = dat_byte;
          st_nxt.crc_tx = rcf_crc_byte(st_r.crc_tx, dat_byte);
          st_nxt.cnt    = st_r.cnt - 8'h01;
          st_nxt.tx     = RCF_TX_DATA;
        end
      end
      RCF_TX_CRCL: begin
        if (tx_ready) begin
          st_nxt.txb = st_r.crc_tx[15:8];
          st_nxt.tx  = RCF_TX_CRCH;
        end
      end
      RCF_TX_CRCH: begin
        if (tx_ready) begin
          st_nxt.tx = RCF_TX_IDLE;
        end
      end
      default: begin
        st_nxt.tx = RCF_TX_IDLE;
      end
    endcase

    // Reply side: running the check over the trailing bytes too leaves zero when intact.
    if (rx_valid) begin
      st_nxt.crc_rx = rcf_crc_byte((st_r.rx_pos == 8'h00) ? RCF_CRC_INIT : st_r.crc_rx,
                                   rx_byte);
      st_nxt.rx_ob  = rx_byte;
      st_nxt.rx_op  = st_r.rx_pos;
      st_nxt.rx_stb = 1'b1;
      if (st_r.rx_pos != 8'hff) begin
        st_nxt.rx_pos = st_r.rx_pos + 8'h01;
      end
      if (st_r.rx_pos == 8'h00) begin
        st_nxt.stat.addr = rx_byte;
      end
      if (st_r.rx_pos == 8'h01) begin
        st_nxt.stat.operation_code_field = rx_byte;
      end
    end else if (st_r.idle == GAP_N && st_r.rx_pos != 8'h00 && !tx_fire) begin
      // Quiet has just exceeded the limit, so the reply frame is complete.
      st_nxt.rx_done      = 1'b1;
      st_nxt.stat.count   = st_r.rx_pos;
      st_nxt.stat.crc_ok  = (st_r.crc_rx == 16'h0000) && (st_r.rx_pos > 8'h03);
      st_nxt.stat.refused = (st_r.stat.operation_code_field == RCF_OP_REFUSED);
      st_nxt.rx_pos       = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_crc_init: assert property (@(posedge mclk) disable iff (!rst_b)
    req_valid && req_ready |=> st_r.crc_tx == 16'hffff)
    else $error("check register not all ones at frame start");

  a_gap_before: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_r.tx == RCF_TX_ADDR) |-> $past(st_r.idle) > GAP_N)
    else $error("frame started without enough quiet");

  a_addr_first: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_valid && st_r.tx == RCF_TX_ADDR |-> tx_byte == st_r.rq.addr)
    else $error("first byte is not the address");

  a_operation_code_field_second: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_fire && st_r.tx == RCF_TX_ADDR |=> tx_byte == st_r.rq.operation_code_field)
    else $error("second byte is not the operation code");

  a_len_third: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_fire && st_r.tx == RCF_TX_OPERATION_CODE_FIELD |=> tx_byte == st_r.rq.payload_length_field)
    else $error("third byte is not the length");

  a_data_count: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_r.tx == RCF_TX_CRCL) |-> st_r.cnt == 8'h00)
    else $error("check sent before all data bytes");

  a_crc_order: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_fire && st_r.tx == RCF_TX_CRCL |=>
      st_r.tx == RCF_TX_CRCH && tx_byte == $past(st_r.crc_tx[15:8]))
    else $error("check high byte not after low byte");

  a_rx_boundary: assert property (@(posedge mclk) disable iff (!rst_b)
    rx_valid ##1 !rx_valid [*2] |-> !rx_done)
    else $error("reply closed before the quiet limit");

  a_fetch_byte: assert property (@(posedge mclk) disable iff (!rst_b)
    dat_valid && dat_ready |=> tx_valid && tx_byte == $past(dat_byte))
    else $error("data byte not passed on in order");

  a_crc_low: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_r.tx == RCF_TX_CRCL) |-> tx_byte == st_r.crc_tx[7:0])
    else $error("check low byte does not follow the data");

  a_stat_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    rx_out_stb && rx_out_pos == 8'h00 |-> rx_stat.addr == rx_out_byte)
    else $error("reply address not taken from the first byte");
endmodule

// ===== design/rcf_pkg.sv
// Package of constants, carriers and the check routine for the binary frame host.
// Assumes one 200 MHz clock and a byte-wide serial transceiver outside the block.
package rcf_pkg;
  localparam logic [15:0] RCF_CRC_INIT   = 16'hffff;
  localparam logic [15:0] RCF_CRC_POLY   = 16'ha001;
  localparam int          RCF_CRC_STEPS  = 8;
  localparam logic [7:0]  RCF_BCAST_ADDR = 8'h00;
  localparam logic [7:0]  RCF_OP_RD_PAR  = 8'h01;
  localparam logic [7:0]  RCF_OP_WR_PAR  = 8'h02;
  localparam logic [7:0]  RCF_OP_WR_CTL  = 8'h03;
  localparam logic [7:0]  RCF_OP_RD_STS  = 8'h04;
  localparam logic [7:0]  RCF_OP_WR_FRQ  = 8'h05;
  localparam logic [7:0]  RCF_OP_LOOP    = 8'h08;
  localparam logic [7:0]  RCF_OP_REFUSED = 8'h81;
  localparam logic [7:0]  RCF_LEN_WORD   = 8'h03;
  localparam logic [7:0]  RCF_LEN_BYTE   = 8'h02;
  localparam int          RCF_QUIET_MS   = 50;
  localparam int          RCF_CLK_KHZ    = 200000;
  localparam int          RCF_QUIET_CYC  = RCF_QUIET_MS * RCF_CLK_KHZ;

  typedef enum logic [3:0] {
    RCF_TX_IDLE  = 4'h0,
    RCF_TX_GAP   = 4'h1,
    RCF_TX_ADDR  = 4'h2,
    RCF_TX_OPERATION_CODE_FIELD  = 4'h3,
    RCF_TX_LEN   = 4'h4,
    RCF_TX_FETCH = 4'h5,
    RCF_TX_DATA  = 4'h6,
    RCF_TX_CRCL  = 4'h7,
    RCF_TX_CRCH  = 4'h8
  } rcf_tx_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] operation_code_field;
    logic [7:0] payload_length_field;
    logic [7:0] count;
  } rcf_req_type;

  typedef struct packed {
    logic       crc_ok;
    logic       refused;
    logic [7:0] count;
    logic [7:0] addr;
    logic [7:0] operation_code_field;
  } rcf_rx_type;

  function automatic logic [15:0] rcf_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] r;
    logic        lsb;
    r = crc ^ {8'h00, b};
    for (int i = 0; i < RCF_CRC_STEPS; i++) begin
      lsb = r[0];
      r = {1'b0, r[15:1]};
      if (lsb) begin
        r = r ^ RCF_CRC_POLY;
      end
    end
    return r;
  endfunction
endpackage

// ===== test/rcf_dev.sv
// Device model and check routine for the host framer bench.
// Assumes the host byte port on mclk and one station address.
`timescale 1ns/10ps
package rcf_tb_pkg;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] r;
    r = 16'hffff;
    foreach (q[i]) begin
      r = r ^ {8'h00, q[i]};
      repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    return r;
  endfunction
endpackage

module rcf_dev
  import rcf_tb_pkg::*;
#(
  parameter int G   = 20,
  parameter int STN = 1
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_valid
);
  logic [7:0]  rq[$];
  logic [7:0]  wq[$];
  logic [15:0] c;
  int          qc = 0;
  int          sd = 7;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // A quarter of cycles stall, so the host must hold its byte.
  always @(posedge mclk) begin
    if (!rst_b) begin
      rq.delete();
      wq.delete();
      qc = 0;
    end else if (tx_valid && tx_ready) begin
      rq.push_back(tx_byte);
      qc = 0;
    end else if (rx_valid) begin
      qc = 0;
    end else begin
      qc++;
    end
    if (qc == G + 1 && rq.size() > 1) begin
      c = crc16(rq);
      if (c == 16'h0000 && rq[0] != 8'h00 && rq[0] == STN) begin
        if (rq[1] inside {[1:5], 8}) wq = {rq[0], rq[1], 8'h02, 8'h5a};
        else wq = {rq[0], 8'h81, 8'h01, rq[1]};
        c = crc16(wq);
        wq.push_back(c[7:0]);
        wq.push_back(c[15:8]);
      end
      rq.delete();
    end
    #1;
    tx_ready = rst_b && ($random(sd) % 4 != 0);
    if (wq.size() > 0 && (qc > G + 1 || rx_valid)) begin
      rx_valid = 1'b1;
      rx_byte  = wq.pop_front();
    end else begin
      rx_valid = 1'b0;
      rx_byte  = ~rx_byte;
    end
  end
endmodule

// ===== test/test_rcf_host.sv
// Self-checking bench: host framer against the device model.
// Assumes the model answers as station 1 with a short gap.
`timescale 1ns/10ps
module test_rcf_host;
  import rcf_pkg::*;
  import rcf_tb_pkg::*;
  localparam int G = 20;
  logic        mclk = 0;
  logic        rst_b = 0;
  rcf_req_type req = '0;
  logic        req_valid = 0;
  logic        req_ready, dat_ready, tx_valid, tx_ready, rx_valid, rx_done;
  logic        dat_valid = 0, rx_out_stb, rv_d = 0;
  logic [7:0]  rx_out_byte, rx_out_pos, rb_d = 0, rp_d = 0;
  int          rc = 0;
  logic [7:0]  dat_byte, tx_byte, rx_byte;
  rcf_rx_type  rx_stat;
  logic [7:0]  dq[8];
  logic [7:0]  got[$];
  logic [7:0]  exp[$];
  logic [7:0]  at[3] = '{8'h00, 8'h01, 8'h05};
  int          n_errors = 0, checks = 0, cyc = 0, di = 0, q = 0;
  int          seed = 20119;
  always #2.5 mclk = ~mclk;
  assign dat_byte = dq[di[2:0]];
  rcf_host #(.GAP_CYCLES(G)) DUT (.mclk(mclk), .rst_b(rst_b), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .dat_byte(dat_byte),
    .dat_valid(dat_valid), .dat_ready(dat_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_out_byte(rx_out_byte), .rx_out_pos(rx_out_pos), .rx_out_stb(rx_out_stb),
    .rx_done(rx_done), .rx_stat(rx_stat));
  // Data is offered with random stalls so the fetch wait is exercised.
  always @(posedge mclk) begin
    #1 dat_valid = rst_b && ({$random(seed)} % 4 != 0);
  end
  rcf_dev #(.G(G), .STN(1)) u_dev (.mclk(mclk), .rst_b(rst_b), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
  task automatic chk8(logic [7:0] a, logic [7:0] e);
    checks++;
    if (a !== e) begin
      n_errors++;
      $display("BAD %0t byte %h want %h", $time, a, e);
    end
  endtask
  task automatic chk1(logic a, logic e);
    checks++;
    if (a !== e) begin
      n_errors++;
      $display("BAD %0t flag %b want %b", $time, a, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
    if (dat_ready && dat_valid) di <= di + 1;
    if (tx_valid && tx_ready) begin
      if (got.size() == 0) chk1(q > G, 1'b1);
      got.push_back(tx_byte);
    end
    q = (tx_valid && tx_ready) || rx_valid || !rst_b ? 0 : q + 1;
    if (rst_b && rv_d) begin
      chk8(rx_out_byte, rb_d);
      chk8(rx_out_pos, rp_d);
    end
    if (rst_b) chk1(rx_out_stb, rv_d);
    if (rx_done || !rst_b) rc = 0;
    rv_d = rx_valid && rst_b;
    rb_d = rx_byte;
    if (rx_valid) begin
      rp_d = rc[7:0];
      rc++;
    end
  end
  task automatic frame(logic [7:0] a, logic [7:0] f, int n);
    logic [15:0] c;
    exp = {a, f, (n >= 2) ? RCF_LEN_WORD : RCF_LEN_BYTE};
    for (int i = 0; i < n; i++) exp.push_back(dq[i]);
    c = crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    got.delete();
    @(posedge mclk);
    #1;
    di = 0;
    req = '{a, f, exp[2], n[7:0]};
    req_valid = 1;
    @(posedge mclk);
    while (req_ready !== 1'b1) @(posedge mclk);
    #1 req_valid = 0;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 999 && req_ready !== 1'b1; k++) @(posedge mclk);
    chk8(8'(got.size()), 8'(exp.size()));
    foreach (exp[i]) chk8(got[i], exp[i]);
    for (int k = 0; k < 3 * G + 40 && rx_done !== 1'b1; k++) @(posedge mclk);
    chk1(rx_done, a == 8'h01);
    if (a == 8'h01) begin
      chk1(rx_stat.crc_ok, 1'b1);
      chk1(rx_stat.refused, !(f inside {[1:5], 8}));
      chk8(rx_stat.count, 8'h06);
      chk8(rx_stat.addr, a);
      chk8(rx_stat.operation_code_field, (f inside {[1:5], 8}) ? f : RCF_OP_REFUSED);
    end
    $display("frame %h %h %0d done", a, f, n);
  endtask
  initial begin
    foreach (dq[i]) dq[i] = 8'h00;
    repeat (16) @(posedge mclk);
    #1 rst_b = 1;
    chk1(req_ready, 1'b1);
    chk1(tx_valid, 1'b0);
    chk1(dat_ready, 1'b0);
    dq[1] = 8'h0b;
    dq[2] = 8'hb8;
    frame(8'h01, 8'h02, 3);
    chk8(got[6], 8'h7f);
    chk8(got[7], 8'h0c);
    for (int f = 1; f <= 9; f++) frame(8'h01, f[7:0], f % 4);
    repeat (12) begin
      foreach (dq[i]) dq[i] = 8'($random(seed));
      frame(at[{$random(seed)} % 3], 8'({$random(seed)} % 9 + 1), {$random(seed)} % 4);
    end
    end_sim();
  end
endmodule
